// *** instr_field_split.sv ***
// combinational field splitter for one instruction word
`include "instr_word_decoder_consts.svh"
module instr_field_split (
  input wire logic [13:0] word,
  output instr_word_pkg::decoded_s dec
);
  import instr_word_pkg::*;
  logic [1:0] grp;
  logic [3:0] op;
  assign grp = word[`IWD_GROUP_HI:`IWD_GROUP_LO];
  assign op = word[11:8];
  // split the word into group and operand fields
  always_comb begin
    dec = '0;
    // (RULE_02) (RULE_12) group from top bits
    unique case (grp)
      `IWD_GRP_BYTE: dec.group = GRP_BYTE;
      `IWD_GRP_BIT: dec.group = GRP_BIT;
      default: dec.group = GRP_LITERAL;
    endcase
    // (RULE_04) seven bit file address
    dec.fileAddr = word[`IWD_FILE_HI:0];
    // (RULE_05) bit select field
    dec.bitSel = word[`IWD_BIT_HI:`IWD_BIT_LO];
    // (RULE_06) eight and eleven bit literals
    dec.lit8 = word[`IWD_LIT8_HI:0];
    dec.lit11 = word[`IWD_LIT11_HI:0];
    // (RULE_03) destination select
    dec.destFile = word[`IWD_DEST_BIT];
    // (RULE_10) only words naming a file read it; op 0000 or 0001 with
    // d=0 are control words or clear-accumulator and name no file
    dec.usesFile = (grp == `IWD_GRP_BYTE &&
                    !(op[3:1] == 3'h0 && !word[7])) ||
                   grp == `IWD_GRP_BIT;
    // (RULE_10) write back on d=1 or bit set/clear
    dec.writesFile = (grp == `IWD_GRP_BYTE && dec.usesFile && word[7]) ||
                     (grp == `IWD_GRP_BIT && !word[11]);
    dec.isJump = (grp == `IWD_GRP_JUMP);
    // (RULE_07) x positions ignored, only fixed bits compared
    dec.isReturn = (grp == `IWD_GRP_LIT && word[11:10] == 2'h1) ||
                   (grp == `IWD_GRP_BYTE && word[11:1] == 11'h004);
    dec.isBitTest = (grp == `IWD_GRP_BIT && word[11]);
    dec.bitTestSet = word[10];
    dec.isSkipOnZero = (grp == `IWD_GRP_BYTE) &&
                       (op == 4'hB || op == 4'hF);
  end
endmodule

// *** instr_word_decoder.sv ***
// instruction word decoder and four-phase cycle sequencer
`include "instr_word_decoder_consts.svh"
////////////////////////////////////////////////////////////////////////
// Function
// (RULE_01) Each instruction is taken as one 14-bit word of opcode and operands.
// (RULE_02) Every word falls in exactly one of byte, bit or literal groups.
// (RULE_03) In the byte group d=0 sends the result to W and d=1 to the file; the code's clear-accumulator (d=0, no file read) writes neither.
// (RULE_04) The file address operand spans registers 0x00 to 0x7F.
// (RULE_05) In the bit group the bit select picks one bit of the file byte.
// (RULE_06) Literal words yield an 8-bit data or 11-bit address operand.
// (RULE_07) Don't-care positions decode the same whatever their value.
// (RULE_08) One instruction cycle is four oscillator periods.
// (RULE_09) A true test or changed counter takes two cycles, the second a nop.
// (RULE_10) A file instruction reads, modifies, then stores to its target.
// (RULE_11) The file read happens even for write-only instructions.
// (RULE_12) Group comes from the top bits, the rest routes to fields.
module instr_word_decoder (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [13:0] instrWord,
  input wire logic [7:0] fileRdData,
  input wire logic zeroResult,
  output logic fetchStrobe,
  output instr_word_pkg::decoded_s decoded,
  output logic [1:0] phase,
  output logic fileRdStrobe,
  output logic fileWrStrobe,
  output logic wrToAccum,
  output logic nopCycle,
  output logic cycleEnd
);
  import instr_word_pkg::*;
  typedef enum {EXEC, FLUSH} slot_e;
  slot_e slot_reg;
  slot_e slot_next;
  logic [1:0] phase_reg;
  decoded_s dec;
  decoded_s decoded_reg;
  logic takeTwo;
  logic bitVal;

  ////////////////////////////////////////////////////////////////////
  // (RULE_01) word split by one splitter
  instr_field_split splitter (
    .word(instrWord),
    .dec(dec)
  );

  // (RULE_08) phase counter wraps every four clocks
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign phase = phase_reg;
  assign cycleEnd = (phase_reg == 2'h3);
  // word fetched at the start of each cycle, latched only in an exec slot
  assign fetchStrobe = resetn && (phase_reg == 2'h0);

  // decoded word held for the whole cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      decoded_reg <= '0;
    end else if (phase_reg == 2'h0 && slot_reg == EXEC) begin
      decoded_reg <= dec;
    end
  end
  assign decoded = decoded_reg;

  // (RULE_05) tested bit of the file byte
  assign bitVal = fileRdData[decoded_reg.bitSel];

  // (RULE_09) second cycle needed on jump, return or true test
  always_comb begin
    takeTwo = decoded_reg.isJump || decoded_reg.isReturn;
    if (decoded_reg.isBitTest) begin
      takeTwo = (bitVal == decoded_reg.bitTestSet);
    end
    if (decoded_reg.isSkipOnZero) begin
      takeTwo = zeroResult;
    end
  end

  // (RULE_09) next slot chosen at cycle end
  always_comb begin
    slot_next = slot_reg;
    if (cycleEnd) begin
      slot_next = (slot_reg == EXEC && takeTwo) ? FLUSH : EXEC;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      slot_reg <= EXEC;
    end else begin
      slot_reg <= slot_next;
    end
  end
  assign nopCycle = (slot_reg == FLUSH);

  ////////////////////////////////////////////////////////////////////
  // (RULE_11) read always issued for any file instruction
  assign fileRdStrobe = resetn && slot_reg == EXEC && phase_reg == 2'h1 &&
                        decoded_reg.usesFile;
  // (RULE_10) store after the read, in the last phase
  assign fileWrStrobe = resetn && slot_reg == EXEC && phase_reg == 2'h3 &&
                        decoded_reg.writesFile;
  // (RULE_03) d=0 result of a file-reading byte word goes to the accumulator
  assign wrToAccum = resetn && slot_reg == EXEC && phase_reg == 2'h3 &&
                     decoded_reg.group == GRP_BYTE &&
                     decoded_reg.usesFile && !decoded_reg.destFile;

  ////////////////////////////////////////////////////////////////////
  // checks below run on clk; all but the reset check are muted in reset
  // (RULE_08) four clocks per cycle
  phase_wrap_a: assert property ( // RULE_08
    @(posedge clk) disable iff (!resetn)
    fetchStrobe |=> !fetchStrobe [*3] ##1 fetchStrobe)
    else $error("phase count not four");

  // (RULE_11) read precedes every write
  read_before_write_a: assert property ( // RULE_11
    @(posedge clk) disable iff (!resetn)
    fileWrStrobe |-> $past(fileRdStrobe, 2))
    else $error("write without read");

  // (RULE_09) flush slot follows a jump
  jump_flush_a: assert property ( // RULE_09
    @(posedge clk) disable iff (!resetn)
    (cycleEnd && !nopCycle && decoded.isJump) |=> nopCycle [*4])
    else $error("jump not two cycles");

  // (RULE_09) flush never repeats
  flush_once_a: assert property ( // RULE_09
    @(posedge clk) disable iff (!resetn)
    (cycleEnd && nopCycle) |=> !nopCycle)
    else $error("flush longer than one cycle");

  // (RULE_10) no file access in a nop slot
  nop_quiet_a: assert property ( // RULE_10
    @(posedge clk) disable iff (!resetn)
    nopCycle |-> !fileWrStrobe && !fileRdStrobe && !wrToAccum)
    else $error("access during nop");

  // (RULE_03) destination exclusive
  dest_excl_a: assert property ( // RULE_03
    @(posedge clk) disable iff (!resetn)
    !(wrToAccum && fileWrStrobe))
    else $error("both destinations written");

  // (RULE_02) literal words never touch a file
  literal_nofile_a: assert property ( // RULE_02
    @(posedge clk) disable iff (!resetn)
    decoded.group == GRP_LITERAL |-> !fileRdStrobe)
    else $error("literal reads a file");

  // (RULE_09) plain byte op stays single
  single_cycle_a: assert property ( // RULE_09
    @(posedge clk) disable iff (!resetn)
    (cycleEnd && !nopCycle && decoded.group == GRP_BYTE &&
     !decoded.isSkipOnZero && !decoded.isReturn) |=> !nopCycle)
    else $error("byte op took two cycles");

  // (RULE_01) decoded word only moves at a fetch
  decode_hold_a: assert property ( // RULE_01
    @(posedge clk) disable iff (!resetn)
    !(fetchStrobe && !nopCycle) |=> $stable(decoded))
    else $error("decoded word changed mid cycle");

  // (RULE_12) group follows the two top bits of the fetched word
  group_route_a: assert property ( // RULE_12
    @(posedge clk) disable iff (!resetn)
    (fetchStrobe && !nopCycle) |=> decoded.group ==
      ($past(instrWord[13]) ? GRP_LITERAL :
       ($past(instrWord[12]) ? GRP_BIT : GRP_BYTE)))
    else $error("group not from top bits");

  // (RULE_04) (RULE_05) file address and bit select carried whole
  addr_route_a: assert property ( // RULE_04 RULE_05
    @(posedge clk) disable iff (!resetn)
    (fetchStrobe && !nopCycle) |=>
      decoded.fileAddr == $past(instrWord[6:0]) &&
      decoded.bitSel == $past(instrWord[9:7]))
    else $error("file or bit field misrouted");

  // (RULE_06) both literal widths carried whole
  lit_route_a: assert property ( // RULE_06
    @(posedge clk) disable iff (!resetn)
    (fetchStrobe && !nopCycle) |=>
      decoded.lit8 == $past(instrWord[7:0]) &&
      decoded.lit11 == $past(instrWord[10:0]))
    else $error("literal misrouted");

  // (RULE_03) destination bit carried to the decoded word
  dest_route_a: assert property ( // RULE_03
    @(posedge clk) disable iff (!resetn)
    (fetchStrobe && !nopCycle) |=> decoded.destFile == $past(instrWord[7]))
    else $error("destination bit misrouted");

  // (RULE_07) return with literal decodes alike for either x pair
  dontcare_a: assert property ( // RULE_07
    @(posedge clk) disable iff (!resetn)
    (fetchStrobe && !nopCycle && instrWord[13:10] == 4'hD) |=>
      decoded.isReturn && decoded.group == GRP_LITERAL)
    else $error("ignored bits changed the decode");

  // (RULE_11) read strobe only in the second phase of an exec slot
  rd_phase_a: assert property ( // RULE_11
    @(posedge clk) disable iff (!resetn)
    fileRdStrobe |-> phase == 2'h1 && !nopCycle)
    else $error("read outside phase one");

  // (RULE_10) store strobes only at cycle end
  wr_phase_a: assert property ( // RULE_10
    @(posedge clk) disable iff (!resetn)
    (fileWrStrobe || wrToAccum) |-> cycleEnd && !nopCycle)
    else $error("store outside last phase");

  // (RULE_10) reset holds every strobe low
  reset_quiet_a: assert property ( // RULE_10
    @(posedge clk)
    !resetn |-> !fetchStrobe && !fileRdStrobe && !fileWrStrobe &&
      !wrToAccum)
    else $error("activity during reset");

  // main scenarios: jump, bit skip, write, return, zero skip
  cov_jump_c: cover property (@(posedge clk) disable iff (!resetn)
    cycleEnd && decoded.isJump && !nopCycle);
  cov_skip_c: cover property (@(posedge clk) disable iff (!resetn)
    cycleEnd && decoded.isBitTest && nopCycle == 1'b0 ##1 nopCycle);
  cov_write_c: cover property (@(posedge clk) disable iff (!resetn)
    fileWrStrobe);
  cov_return_c: cover property (@(posedge clk) disable iff (!resetn)
    cycleEnd && decoded.isReturn && !nopCycle ##1 nopCycle);
  cov_zero_skip_c: cover property (@(posedge clk) disable iff (!resetn)
    cycleEnd && decoded.isSkipOnZero && !nopCycle ##1 nopCycle);
endmodule

// *** instr_word_decoder_consts.svh ***
// constants for the instruction word decoder: field positions and timing
`ifndef INSTR_WORD_DECODER_CONSTS_SVH
`define INSTR_WORD_DECODER_CONSTS_SVH
`define IWD_WORD_W 14
`define IWD_GROUP_HI 13
`define IWD_GROUP_LO 12
`define IWD_DEST_BIT 7
`define IWD_FILE_HI 6
`define IWD_BIT_HI 9
`define IWD_BIT_LO 7
`define IWD_LIT8_HI 7
`define IWD_LIT11_HI 10
`define IWD_PHASES 4
`define IWD_GRP_BYTE 2'h0
`define IWD_GRP_BIT 2'h1
`define IWD_GRP_JUMP 2'h2
`define IWD_GRP_LIT 2'h3
`endif

// *** instr_word_decoder_tb_top.sv ***
// self-checking bench for the instruction word decoder
module instr_word_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import instr_word_pkg::*;
  logic clk = 0, resetn = 0, zeroResult = 0;
  logic [13:0] word = 14'h0000, instrWord;
  logic [7:0] fileRdData = 8'h00;
  logic fetchStrobe, fileRdStrobe, fileWrStrobe, wrToAccum, nopCycle, cycleEnd;
  logic [1:0] phase;
  decoded_s decoded;
  int err_count = 0, n_compared = 0, seed = 51033;
  // corners: clear file, store, jump, literal, return, clear-accumulator
  // with x bits set, plain literal with x set, watchdog clear
  logic [13:0] corner [8] = '{14'h0180, 14'h00FF, 14'h2805, 14'h3300,
    14'h0008, 14'h017F, 14'h3DFF, 14'h0064};
  instr_word_decoder u_instr_word_decoder (.clk(clk), .resetn(resetn),
    .instrWord(instrWord), .fileRdData(fileRdData), .zeroResult(zeroResult),
    .fetchStrobe(fetchStrobe), .decoded(decoded), .phase(phase),
    .fileRdStrobe(fileRdStrobe), .fileWrStrobe(fileWrStrobe),
    .wrToAccum(wrToAccum), .nopCycle(nopCycle), .cycleEnd(cycleEnd));
  prog_mem_model u_prog_mem_model (.fetchStrobe(fetchStrobe), .word(word),
    .instrWord(instrWord));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic reads_file(logic [13:0] w);
    return w[13] ? 1'b0 : (w[12] | w[7] | (w[11:9] != 3'h0));
  endfunction
  function automatic logic exp_nop(logic [13:0] w, logic [7:0] rd, logic z);
    case (w[13:12])
      2'h0: return (w[11:8] == 4'hB || w[11:8] == 4'hF) ? z :
                   (w[11:1] == 11'h004);
      2'h1: return w[11] & (rd[w[9:7]] == w[10]);
      2'h2: return 1'b1;
      default: return w[11:10] == 2'h1;
    endcase
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one instruction: fetch, decode checks, write-back, optional flush
  task automatic run(logic [13:0] w);
    logic nop;
    word = w;
    fileRdData = 8'($random(seed));
    zeroResult = 1'($random(seed));
    nop = exp_nop(w, fileRdData, zeroResult);
    // look half a clock on, so a reset release just made has settled
    @(negedge clk);
    check("fetch", fetchStrobe, 1'b1);
    @(posedge clk);
    #1;
    check("phase1", phase, 2'h1);
    // group and operand routing
    check("group", decoded.group, w[13] ? GRP_LITERAL :
          (w[12] ? GRP_BIT : GRP_BYTE));
    if (!w[13]) check("file", decoded.fileAddr, w[6:0]);
    if (w[13:12] == 2'h0) check("dest", decoded.destFile, w[7]);
    if (w[13:12] == 2'h1) check("bit", decoded.bitSel, w[9:7]);
    if (w[13]) check("lit8", decoded.lit8, w[7:0]);
    if (w[13]) check("lit11", decoded.lit11, w[10:0]);
    check("read", fileRdStrobe, reads_file(w));
    repeat (2) @(posedge clk);
    #1;
    check("end", cycleEnd, 1'b1);
    // write-back target of read-modify-write
    check("wrFile", fileWrStrobe, !w[13] && reads_file(w) &&
          (w[12] ? !w[11] : w[7]));
    if (w[13:12] == 2'h0 && reads_file(w))
      check("wrAcc", wrToAccum, !w[7]);
    @(posedge clk);
    #1;
    check("nop", nopCycle, nop);
    if (nop) begin
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  initial begin
    logic [13:0] w;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1;
    foreach (corner[i]) run(corner[i]);
    // reset again mid-run: fetch strobe drops, phase and fields clear
    resetn = 0;
    @(posedge clk);
    #1;
    check("rstPhase", phase, 2'h0);
    check("rstFile", decoded.fileAddr, 7'h00);
    check("rstFetch", fetchStrobe, 1'b0);
    resetn = 1;
    repeat (200) begin
      w = 14'($random(seed));
      if (w[13:12] == 2'h0 && w[11:9] == 3'h0) w[11] = 1'b1;
      run(w);
    end
    end_sim();
  end
  initial begin
    #40000;
    err_count++;
    end_sim();
  end
endmodule

// *** instr_word_pkg.sv ***
// types shared by the instruction word decoder files
package instr_word_pkg;
  typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LITERAL} group_e;
  typedef struct packed {
    group_e group;
    logic destFile;
    logic [6:0] fileAddr;
    logic [2:0] bitSel;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic usesFile;
    logic writesFile;
    logic isJump;
    logic isReturn;
    logic isBitTest;
    logic isSkipOnZero;
    logic bitTestSet;
  } decoded_s;
endpackage

// *** prog_mem_model.sv ***
// program memory model presenting one instruction word per fetch
module prog_mem_model (
  input wire logic fetchStrobe,
  input wire logic [13:0] word,
  output logic [13:0] instrWord
);
  timeunit 1ns;
  timeprecision 100ps;
  // outside the fetch phase the bus shows junk, so late sampling shows up
  assign instrWord = fetchStrobe ? word : ~word;
endmodule
